// ===== hdl/pob_pkg.sv
package pob_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // device register map (offsets within the channel's transmit path block)
  localparam logic [11:0] POB_SEL_OFS = 12'h982;
  localparam logic [11:0] POB_Z3_OFS  = 12'h9ab;
  localparam logic [11:0] POB_Z4_OFS  = 12'h9af;
  localparam logic [11:0] POB_Z5_OFS  = 12'h9b3;

  // source select fields
  localparam int          POB_SEL_H4_BIT = 0;
  localparam int          POB_SEL_Z3_BIT = 1;
  localparam logic [7:0]  POB_SEL_RW_MASK = 8'h0f;
  localparam logic [7:0]  POB_SEL_RST     = 8'h00;
  localparam logic [7:0]  POB_VAL_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // serial timing, in overhead clock periods
  localparam int POB_Z3_WAIT    = 48;
  localparam int POB_BYTE_BITS  = 8;
  localparam int POB_NUM_BYTES  = 3;
  localparam int POB_FIRST_RISE = POB_Z3_WAIT + 1;
  localparam int POB_LAST_RISE  = POB_Z3_WAIT + POB_NUM_BYTES * POB_BYTE_BITS;

  ////////////////////////////////////////////////////////////////////////////////
  // host register map (byte addresses) and control fields
  localparam logic [7:0] POB_HA_CTRL   = 8'h00;
  localparam logic [7:0] POB_HA_Z3     = 8'h04;
  localparam logic [7:0] POB_HA_Z4     = 8'h08;
  localparam logic [7:0] POB_HA_Z5     = 8'h0c;
  localparam logic [7:0] POB_HA_STATUS = 8'h10;
  localparam int         POB_HC_RUN    = 0;
  localparam int         POB_HC_INSREQ = 1;
  localparam int         POB_HC_EN_Z3  = 4;
  localparam logic [31:0] POB_HCFG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    POB_BUS_IDLE = 2'b00,
    POB_BUS_WAIT = 2'b01,
    POB_BUS_DONE = 2'b11
  } pob_bus_st_t;

endpackage

// ===== hdl/pob_link_if.sv
interface pob_link_if;
  logic overhead_serial_clock;
  logic overhead_window_strobe;
  logic overhead_frame_strobe;
  logic overhead_serial_in;
  logic overhead_insert_request;

  modport dev (
    output overhead_serial_clock,
    output overhead_window_strobe,
    output overhead_frame_strobe,
    input  overhead_serial_in,
    input  overhead_insert_request
  );

  modport host (
    input  overhead_serial_clock,
    input  overhead_window_strobe,
    input  overhead_frame_strobe,
    output overhead_serial_in,
    output overhead_insert_request
  );
endinterface

// ===== hdl/pob_device.sv
// Functional notes
// RULE_01 - outside logic samples strobes every rising edge; host samples them only while not busy
// RULE_02 - outside logic waits 48 clocks before z3
// RULE_03 - msb first, changed on falling edge
// RULE_04 - device latches each bit on next rise
// RULE_05 - seven more bits on next falling edges
// RULE_06 - outside logic rearms and repeats every frame
// RULE_07 - z3 is the seventh overhead byte
// RULE_08 - z4 is the eighth overhead byte
// RULE_09 - select register: z5,z4,z3,h4 at bits 3..0
// RULE_10 - z4 select 0 inserts z4 value register
// RULE_11 - eight bit read write z4 value register
// RULE_12 - z4 select 1 inserts serial port byte
// RULE_13 - insert request optional when select is serial
// RULE_14 - z5 sourced from register or serial port
// RULE_15 - outside logic waits 56 clocks before z4
// RULE_16 - settings hold; source change at next frame
module pob_device
  import pob_pkg::*;
#(
  parameter int HALF_PERIOD = 4,
  parameter int FRAME_RISES = 80
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  pob_link_if.dev          link,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic [7:0]       z3_byte_o,
  output logic [7:0]       z4_byte_o,
  output logic [7:0]       z5_byte_o,
  output logic [2:0]       poh_serial_o,
  output logic             poh_valid_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (HALF_PERIOD < 3)
  begin : g_bad_half
    $error("HALF_PERIOD must be at least 3");
  end
  if (FRAME_RISES <= POB_LAST_RISE)
  begin : g_bad_frame
    $error("FRAME_RISES must exceed the last overhead bit position");
  end
  if (POB_BYTE_BITS != (1 << $clog2(POB_BYTE_BITS)) || POB_NUM_BYTES > 3)
  begin : g_bad_slots
    $error("byte slots need a power of two bits and at most three bytes");
  end

  localparam int DW = $clog2(HALF_PERIOD + 1);
  localparam int CW = $clog2(FRAME_RISES + 1);

  localparam logic [DW-1:0] DIV_LAST   = DW'(HALF_PERIOD - 1);
  localparam logic [CW-1:0] RISE_LAST  = CW'(FRAME_RISES - 1);
  localparam logic [CW-1:0] SLOT_FIRST = CW'(POB_FIRST_RISE);
  localparam logic [CW-1:0] SLOT_LAST  = CW'(POB_LAST_RISE);

  // bit index width in a byte slot, its last bit, and the slot closing a frame
  localparam int               BIT_W    = $clog2(POB_BYTE_BITS);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(POB_BYTE_BITS - 1);
  localparam logic [1:0]       SLOT_Z5  = 2'(POB_NUM_BYTES - 1);

  typedef struct packed {
    logic [7:0]      sel;
    logic [2:0][7:0] val;
    logic [7:0]      rdata;
    logic [DW-1:0]   div;
    logic            oclk;
    logic            win;
    logic            frm;
    logic [CW-1:0]   rise;
    logic [2:0]      fsel;
    logic [2:0]      slot_ins;
    logic [7:0]      shf;
    logic [2:0][7:0] obyte;
    logic [2:0]      oser;
    logic            ovalid;
    logic            sin_m;
    logic            sin_s;
    logic            ins_m;
    logic            ins_s;
  } pob_dev_st_t;

  pob_dev_st_t st_reg;
  pob_dev_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin : p_next
    logic [CW-1:0] off;
    logic [1:0]    b;
    logic [7:0]    full;
    logic          ser;
    off  = '0;
    b    = '0;
    full = '0;
    ser  = 1'b0;
    st_next = st_reg;
    st_next.ovalid = 1'b0;

    // pin synchronisers
    st_next.sin_m = link.overhead_serial_in;
    st_next.sin_s = st_reg.sin_m;
    st_next.ins_m = link.overhead_insert_request;
    st_next.ins_s = st_reg.ins_m;

    // register writes; values hold until rewritten
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        POB_SEL_OFS: st_next.sel = reg_wdata_i & POB_SEL_RW_MASK; // see RULE_09 see RULE_16
        POB_Z3_OFS:  st_next.val[0] = reg_wdata_i;
        POB_Z4_OFS:  st_next.val[1] = reg_wdata_i; // see RULE_11
        POB_Z5_OFS:  st_next.val[2] = reg_wdata_i; // see RULE_14
        default:     st_next.sel = st_reg.sel;
      endcase
    end

    // register reads, one cycle after the address
    case (reg_addr_i)
      POB_SEL_OFS: st_next.rdata = st_reg.sel & POB_SEL_RW_MASK; // see RULE_09
      POB_Z3_OFS:  st_next.rdata = st_reg.val[0];
      POB_Z4_OFS:  st_next.rdata = st_reg.val[1]; // see RULE_11
      POB_Z5_OFS:  st_next.rdata = st_reg.val[2];
      default:     st_next.rdata = 8'h00;
    endcase

    // overhead clock divider
    if (st_reg.div == DIV_LAST)
    begin
      st_next.div  = '0;
      st_next.oclk = ~st_reg.oclk;
      if (st_reg.oclk)
      begin
        // falling edge: strobes change for the coming rise
        st_next.win = (st_reg.rise <= SLOT_LAST);
        st_next.frm = (st_reg.rise == '0);
      end
      else
      begin
        // rising edge: frame start takes the selects for this frame
        if (st_reg.rise == '0)
        begin
          st_next.fsel     = st_reg.sel[POB_SEL_Z3_BIT +: POB_NUM_BYTES]; // see RULE_16
          st_next.slot_ins = '0;
        end
        if (st_reg.rise >= SLOT_FIRST && st_reg.rise <= SLOT_LAST)
        begin
          // z3, z4, z5 occupy consecutive byte slots after the wait
          off  = st_reg.rise - SLOT_FIRST; // see RULE_07 see RULE_08
          b    = off[BIT_W +: 2];
          full = {st_reg.shf[6:0], st_reg.sin_s}; // see RULE_04 see RULE_03
          st_next.shf = full;
          if (st_reg.ins_s)
          begin
            st_next.slot_ins[b] = 1'b1; // see RULE_13
          end
          if (off[BIT_W-1:0] == BIT_LAST)
          begin
            ser = st_reg.fsel[b] | st_reg.slot_ins[b] | st_reg.ins_s;
            // serial byte or value register per select, serial whenever insert request is set
            st_next.obyte[b] = ser ? full : st_reg.val[b]; // see RULE_10 see RULE_12 see RULE_14
            st_next.oser[b]  = ser;
            st_next.ovalid   = (b == SLOT_Z5);
          end
        end
        st_next.rise = (st_reg.rise == RISE_LAST) ? '0 : st_reg.rise + 1'b1;
      end
    end
    else
    begin
      st_next.div = st_reg.div + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg          <= '0;
      st_reg.sel      <= POB_SEL_RST;
      st_reg.val      <= {3{POB_VAL_RST}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.overhead_serial_clock  = st_reg.oclk;
  assign link.overhead_window_strobe = st_reg.win;
  assign link.overhead_frame_strobe  = st_reg.frm;
  assign reg_rdata_o  = st_reg.rdata;
  assign z3_byte_o    = st_reg.obyte[0];
  assign z4_byte_o    = st_reg.obyte[1];
  assign z5_byte_o    = st_reg.obyte[2];
  assign poh_serial_o = st_reg.oser;
  assign poh_valid_o  = st_reg.ovalid;

endmodule // pob_device

// ===== hdl/pob_host.sv
module pob_host
  import pob_pkg::*;
#(
  parameter int FRAME_CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  pob_link_if.host         link,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  if (FRAME_CNT_W < 1 || FRAME_CNT_W > 32)
  begin : g_bad_cnt
    $error("FRAME_CNT_W must be 1 to 32");
  end

  localparam logic [6:0] P_FIRST = 7'(POB_Z3_WAIT);
  localparam logic [6:0] P_LAST  = 7'(POB_LAST_RISE);

  typedef struct packed {
    pob_bus_st_t            bst;
    logic [31:0]            cfg;
    logic                   req;
    logic                   ack_m;
    logic                   ack_s;
    logic                   dn_m;
    logic                   dn_s;
    logic                   dn_d;
    logic [FRAME_CNT_W-1:0] frames;
    logic [31:0]            rdata;
    logic                   wait_r;
  } pob_hbus_st_t;

  typedef struct packed {
    logic        rq_m;
    logic        rq_s;
    logic        ack;
    logic [31:0] lcfg;
    logic        busy;
    logic [6:0]  pos;
    logic        done;
  } pob_hlnk_st_t;

  pob_hbus_st_t b_reg;
  pob_hbus_st_t b_next;
  pob_hlnk_st_t l_reg;
  pob_hlnk_st_t l_next;
  logic         drv_bit_reg;
  logic         drv_ins_reg;
  logic         bit_next;

  ////////////////////////////////////////////////////////////////////////////////
  // bus side: writes to mapped registers wait for the link side to take the settings
  always_comb
  begin
    b_next = b_reg;
    b_next.ack_m = l_reg.ack;
    b_next.ack_s = b_reg.ack_m;
    b_next.dn_m  = l_reg.done;
    b_next.dn_s  = b_reg.dn_m;
    b_next.dn_d  = b_reg.dn_s;
    if (b_reg.dn_s != b_reg.dn_d)
    begin
      b_next.frames = b_reg.frames + 1'b1;
    end
    case (b_reg.bst)
      POB_BUS_IDLE:
      begin
        if (avs_write_i)
        begin
          b_next.bst    = POB_BUS_WAIT;
          b_next.req    = ~b_reg.req;
          case (avs_address_i)
            POB_HA_CTRL: b_next.cfg[7:0]   = avs_writedata_i[7:0];
            POB_HA_Z3:   b_next.cfg[15:8]  = avs_writedata_i[7:0];
            POB_HA_Z4:   b_next.cfg[23:16] = avs_writedata_i[7:0];
            POB_HA_Z5:   b_next.cfg[31:24] = avs_writedata_i[7:0];
            default:
            begin
              b_next.bst    = POB_BUS_DONE;
              b_next.req    = b_reg.req;
              b_next.wait_r = 1'b0;
            end
          endcase
        end
        else if (avs_read_i)
        begin
          b_next.bst    = POB_BUS_DONE;
          b_next.wait_r = 1'b0;
          case (avs_address_i)
            POB_HA_CTRL:   b_next.rdata = {24'h0, b_reg.cfg[7:0]};
            POB_HA_Z3:     b_next.rdata = {24'h0, b_reg.cfg[15:8]};
            POB_HA_Z4:     b_next.rdata = {24'h0, b_reg.cfg[23:16]};
            POB_HA_Z5:     b_next.rdata = {24'h0, b_reg.cfg[31:24]};
            POB_HA_STATUS: b_next.rdata = 32'(b_reg.frames);
            default:       b_next.rdata = 32'h0;
          endcase
        end
      end
      POB_BUS_WAIT:
      begin
        if (b_reg.ack_s == b_reg.req)
        begin
          b_next.bst    = POB_BUS_DONE;
          b_next.wait_r = 1'b0;
        end
      end
      POB_BUS_DONE:
      begin
        b_next.bst    = POB_BUS_IDLE;
        b_next.wait_r = 1'b1;
      end
      default:
      begin
        b_next.bst    = POB_BUS_IDLE;
        b_next.wait_r = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      b_reg        <= '0;
      b_reg.bst    <= POB_BUS_IDLE;
      b_reg.cfg    <= POB_HCFG_RST;
      b_reg.wait_r <= 1'b1;
    end
    else
    begin
      b_reg <= b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link side: watch strobes, wait, then shift z3, z4, z5
  always_comb
  begin : p_link
    logic [6:0] off;
    logic [1:0] idx;
    off = l_reg.pos - P_FIRST;
    idx = off[4:3];
    l_next = l_reg;
    l_next.rq_m = b_reg.req;
    l_next.rq_s = l_reg.rq_m;
    if (l_reg.rq_s != l_reg.ack)
    begin
      l_next.lcfg = b_reg.cfg;
      l_next.ack  = l_reg.rq_s;
    end
    if (!l_reg.busy)
    begin
      // strobes sampled on every rise while not busy
      if (l_reg.lcfg[POB_HC_RUN] && link.overhead_window_strobe
          && link.overhead_frame_strobe) // see RULE_01
      begin
        l_next.busy = 1'b1;
        l_next.pos  = '0;
      end
    end
    else if (l_reg.pos == P_LAST - 1'b1)
    begin
      l_next.busy = 1'b0; // see RULE_06
      l_next.done = ~l_reg.done;
    end
    else
    begin
      l_next.pos = l_reg.pos + 1'b1;
    end
    // bit for the coming fall: z3 after 48, z4 after 56, z5 after 64
    bit_next = 1'b0;
    if (l_reg.busy && l_reg.pos >= P_FIRST && l_reg.pos < P_LAST) // see RULE_02 see RULE_15
    begin
      bit_next = l_reg.lcfg[POB_HC_EN_Z3 + 32'(idx)]
                 & l_reg.lcfg[8 + 8 * 32'(idx) + 7 - 32'(off[2:0])]; // see RULE_03 see RULE_05
    end
  end

  always_ff @(posedge link.overhead_serial_clock or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      l_reg      <= '0;
      l_reg.lcfg <= POB_HCFG_RST;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // pins change on the falling edge
  always_ff @(negedge link.overhead_serial_clock or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      drv_bit_reg <= 1'b0;
      drv_ins_reg <= 1'b0;
    end
    else
    begin
      drv_bit_reg <= bit_next; // see RULE_03
      drv_ins_reg <= l_reg.lcfg[POB_HC_INSREQ] & l_reg.busy; // see RULE_13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.overhead_serial_in      = drv_bit_reg;
  assign link.overhead_insert_request = drv_ins_reg;
  assign avs_readdata_o    = b_reg.rdata;
  assign avs_waitrequest_o = b_reg.wait_r;

endmodule // pob_host

// ===== test/pob_link_sva.sv
module pob_link_sva
  import pob_pkg::*;
#(
  parameter int HALF_PERIOD = 4,
  parameter int FRAME_RISES = 80
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic overhead_serial_clock,
  input wire logic overhead_window_strobe,
  input wire logic overhead_frame_strobe,
  input wire logic overhead_serial_in,
  input wire logic overhead_insert_request
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // helper counters
  logic [7:0] rise_cnt_reg;
  logic       seen_reg;
  logic [7:0] half_cnt_reg;
  logic       sck_q_reg;
  logic       started_reg;

  always_ff @(posedge overhead_serial_clock or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rise_cnt_reg <= 8'h00;
      seen_reg     <= 1'b0;
    end
    else if (overhead_frame_strobe)
    begin
      rise_cnt_reg <= 8'h01;
      seen_reg     <= 1'b1;
    end
    else
      rise_cnt_reg <= rise_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      half_cnt_reg <= 8'h00;
      sck_q_reg    <= 1'b0;
      started_reg  <= 1'b0;
    end
    else
    begin
      sck_q_reg <= overhead_serial_clock;
      if (overhead_serial_clock != sck_q_reg)
      begin
        half_cnt_reg <= 8'h00;
        started_reg  <= 1'b1;
      end
      else
        half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link timing
  a_frame_single: assert property (@(posedge overhead_serial_clock)
    disable iff (!rst_b_i) overhead_frame_strobe |=> !overhead_frame_strobe)
    else $error("frame strobe too long");
  a_frame_in_window: assert property (@(posedge overhead_serial_clock)
    disable iff (!rst_b_i) overhead_frame_strobe |-> overhead_window_strobe)
    else $error("frame outside window");
  a_frame_period: assert property (@(posedge overhead_serial_clock)
    disable iff (!rst_b_i) overhead_frame_strobe && seen_reg |-> rise_cnt_reg == FRAME_RISES)
    else $error("frame period wrong");
  a_window_span: assert property (@(posedge overhead_serial_clock)
    disable iff (!rst_b_i) seen_reg && !overhead_frame_strobe
    |-> overhead_window_strobe == (rise_cnt_reg <= 8'(POB_LAST_RISE)))
    else $error("window span wrong");
  a_wait_quiet: assert property (@(posedge overhead_serial_clock)
    disable iff (!rst_b_i) seen_reg && rise_cnt_reg >= 8'h02
    && rise_cnt_reg <= 8'(POB_Z3_WAIT) |-> $stable(overhead_serial_in))
    else $error("serial data moved in wait");
  a_data_on_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $changed(overhead_serial_in) |-> !overhead_serial_clock) else $error("data not on fall");
  a_strobe_on_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $changed(overhead_frame_strobe) || $changed(overhead_window_strobe) |-> !overhead_serial_clock)
    else $error("strobe not on fall");
  a_clock_divider: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    started_reg && overhead_serial_clock != sck_q_reg |-> half_cnt_reg == HALF_PERIOD - 1)
    else $error("link clock half period wrong");

  c_frame: cover property (@(posedge overhead_serial_clock) overhead_frame_strobe);
  c_insert: cover property (@(posedge clk_i) $rose(overhead_insert_request));
  c_first_bit: cover property (@(posedge overhead_serial_clock)
    rise_cnt_reg == 8'(POB_FIRST_RISE) && $changed(overhead_serial_in));
endmodule // pob_link_sva

// ===== test/tb_top.sv
module tb_top
  import pob_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HP = 3;
  localparam int FR = 76;
  logic        clk_i, rst_b_i, reg_wr_i, avs_read_i, avs_write_i;
  logic [11:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, z3_byte_o, z4_byte_o, z5_byte_o, avs_address_i, d8;
  logic [2:0]  poh_serial_o;
  logic        poh_valid_o, avs_waitrequest_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, s0;
  int          err_count, cmp_count;

  pob_link_if link_if ();
  pob_device #(.HALF_PERIOD(HP), .FRAME_RISES(FR)) pob_device_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .link(link_if), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .z3_byte_o(z3_byte_o),
    .z4_byte_o(z4_byte_o), .z5_byte_o(z5_byte_o), .poh_serial_o(poh_serial_o),
    .poh_valid_o(poh_valid_o));
  pob_host pob_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));
  pob_link_sva #(.HALF_PERIOD(HP), .FRAME_RISES(FR)) pob_link_sva_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .overhead_serial_clock(link_if.overhead_serial_clock),
    .overhead_window_strobe(link_if.overhead_window_strobe),
    .overhead_frame_strobe(link_if.overhead_frame_strobe),
    .overhead_serial_in(link_if.overhead_serial_in),
    .overhead_insert_request(link_if.overhead_insert_request));

  ////////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic dev_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic dev_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    d = reg_rdata_o;
  endtask

  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wait_frames(input int n);
    repeat (n)
    begin
      do @(posedge clk_i); while (poh_valid_o !== 1'b1);
    end
  endtask

  task automatic check_out(input logic [2:0] ser, input logic [7:0] e3, e4, e5);
    wait_frames(2);
    check("z3_byte", 32'(z3_byte_o), 32'(e3));
    check("z4_byte", 32'(z4_byte_o), 32'(e4));
    check("z5_byte", 32'(z5_byte_o), 32'(e5));
    check("source", 32'(poh_serial_o), 32'(ser));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, sequence
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end

  initial
  begin
    {rst_b_i, reg_wr_i, avs_read_i, avs_write_i, reg_addr_i, reg_wdata_i} = '0;
    {avs_address_i, avs_writedata_i} = '0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    dev_rd(POB_SEL_OFS, d8);
    check("sel_reset", 32'(d8), 32'(POB_SEL_RST));
    dev_rd(POB_Z4_OFS, d8);
    check("z4_reset", 32'(d8), 32'(POB_VAL_RST));
    av_xfer(1'b0, POB_HA_CTRL, 32'h0, q);
    check("ctrl_reset", q, POB_HCFG_RST);
    dev_wr(POB_SEL_OFS, 8'hff);
    dev_rd(POB_SEL_OFS, d8);
    check("sel_ro_bits", 32'(d8), 32'(POB_SEL_RW_MASK));
    dev_wr(POB_Z4_OFS, 8'h81);
    dev_rd(POB_Z4_OFS, d8);
    check("z4_value", 32'(d8), 32'h81);
    dev_wr(12'h9a0, 8'h55);
    dev_rd(12'h9a0, d8);
    check("dev_unmapped", 32'(d8), 32'h0);
    av_xfer(1'b1, 8'h20, 32'hff, q);
    av_xfer(1'b0, 8'h20, 32'h0, q);
    check("host_unmapped", q, 32'h0);
    dev_wr(POB_SEL_OFS, 8'h00);
    dev_wr(POB_Z3_OFS, 8'h3c);
    dev_wr(POB_Z4_OFS, 8'ha5);
    dev_wr(POB_Z5_OFS, 8'h5a);
    av_xfer(1'b1, POB_HA_Z3, 32'h81, q);
    av_xfer(1'b1, POB_HA_Z4, 32'h7e, q);
    av_xfer(1'b1, POB_HA_Z5, 32'h96, q);
    av_xfer(1'b1, POB_HA_CTRL, 32'h71, q);
    check_out(3'b000, 8'h3c, 8'ha5, 8'h5a);
    dev_wr(POB_SEL_OFS, 8'h0e);
    check_out(3'b111, 8'h81, 8'h7e, 8'h96);
    repeat (40) @(posedge clk_i);
    av_xfer(1'b0, POB_HA_STATUS, 32'h0, s0);
    wait_frames(1);
    repeat (40) @(posedge clk_i);
    av_xfer(1'b0, POB_HA_STATUS, 32'h0, q);
    check("frame_count", q, s0 + 32'h1);
    dev_wr(POB_SEL_OFS, 8'h04);
    av_xfer(1'b1, POB_HA_Z4, 32'hc3, q);
    check_out(3'b010, 8'h3c, 8'hc3, 8'h5a);
    dev_rd(POB_SEL_OFS, d8);
    check("sel_hold", 32'(d8), 32'h04);
    dev_wr(POB_SEL_OFS, 8'h00);
    av_xfer(1'b1, POB_HA_CTRL, 32'h13, q);
    check_out(3'b111, 8'h81, 8'h00, 8'h00);
    give_verdict();
  end
endmodule // tb_top
